//--- shared/cmoh_params.svh
`ifndef CMOH_PARAMS_SVH
`define CMOH_PARAMS_SVH
`define CMOH_NOBJ           32
`define CMOH_FLAG_SET       2'h2
`define CMOH_FLAG_CLR       2'h1
// Per-object word index inside a 32-byte object (addr = obj*8 + word)
`define CMOH_W_CTRL         3'h0
`define CMOH_W_SETUP        3'h1
`define CMOH_W_ID           3'h2
`define CMOH_W_MASK         3'h3
`define CMOH_W_PLO          3'h4
`define CMOH_W_PHI          3'h5
`define CMOH_W_FGC          3'h6
// Node frame counter controls at the top of the map
`define CMOH_A_FCA          8'hF8
`define CMOH_A_FCB          8'hF9
// Control word fields
`define CMOH_C_VAL          1:0
`define CMOH_C_SEND_REQUEST_FIELD         3:2
`define CMOH_C_NEW          5:4
`define CMOH_C_LOCK         7:6
`define CMOH_C_RMT          9:8
`define CMOH_C_SEND_IRQ_ENABLE         11:10
`define CMOH_C_RECEIVE_IRQ_ENABLE         13:12
`define CMOH_C_IPND         14
`define CMOH_C_TXIP         15
`define CMOH_C_RXIP         16
`define CMOH_C_SNAP         31:24
// Setup word fields
`define CMOH_S_DIR          0
`define CMOH_S_NODE         1
`define CMOH_S_XTD          2
`define CMOH_S_RMM          3
`define CMOH_S_DLC          7:4
// Gateway/buffer control word field and frame counter enable bit
`define CMOH_G_SDT          0
`define CMOH_FC_EN          16
`endif

//--- shared/cmoh_pkg.sv
package cmoh_pkg;
    typedef enum logic [1:0] {
        CMOH_IDLE,
        CMOH_BUSY
    } cmoh_tx_e;
endpackage : cmoh_pkg

//--- src/cmoh_handler.sv
`timescale 1ns/1ps
`include "cmoh_params.svh"
// Notes on behaviour
// - Direction bit 1 transmit, 0 receive
// - Only valid objects take part
// - Remote watch copies identifier and length
// - Accepted remote sets send request and pending
// - Software write may raise send request
// - Unlocked valid request sends data frame, or remote frame from a receive object
// - Lock blocks request evaluation and sending
// - Remote under lock still sets flags
// - Lowest numbered pending object sends first
// - Fresh content cleared when payload handed over
// - Success clears send request and pending
// - Success stores snapshot, pends irq, counts
// - Transmit object ignores received data frames
// - Data frame stores payload and length
// - Overwrite flagged when fresh still set
// - Receive stores snapshot, pends irq, counts
// - Receive object lock position gates remote
// - Remote sent clears flags, send irq
// - Receive object ignores remote frames
// - One-shot clears valid after data sent
// - Without one-shot valid is cleared only by a software write
// - Lowest numbered accepting object stores frame
module cmoh_handler (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Received frame from bitstream processors
    input  wire logic        rx_vld_i,
    input  wire logic        rx_node_i,
    input  wire logic        rx_rtr_i,
    input  wire logic        rx_xtd_i,
    input  wire logic [28:0] rx_id_i,
    input  wire logic [3:0]  rx_dlc_i,
    input  wire logic [63:0] rx_data_i,
    // Transmit request to node A (0) and node B (1)
    input  wire logic [1:0]  bus_idle_i,
    output logic      [1:0]  tx_req_o,
    output logic      [9:0]  tx_obj_o,
    output logic      [1:0]  tx_rtr_o,
    output logic      [1:0]  tx_xtd_o,
    output logic      [57:0] tx_id_o,
    output logic      [7:0]  tx_dlc_o,
    output logic      [127:0] tx_data_o,
    input  wire logic [1:0]  tx_done_i,
    input  wire logic [1:0]  tx_fail_i
);
    localparam int N = `CMOH_NOBJ;
    logic [31:0] ctrl_r  [N];
    logic [31:0] setup_r [N];
    logic [31:0] id_r    [N];
    logic [31:0] mask_r  [N];
    logic [31:0] plo_r   [N];
    logic [31:0] phi_r   [N];
    logic [31:0] fgc_r   [N];
    logic [31:0] fca_r;
    logic [31:0] fcb_r;
    logic [31:0] rdata_r;
    cmoh_pkg::cmoh_tx_e tst_r [2];
    logic [4:0]  tobj_r [2];

    logic [4:0]  wobj;
    logic [2:0]  wsel;
    assign wobj = addr_i[7:3];
    assign wsel = addr_i[2:0];

    // Flag field update on software write
    function automatic logic [1:0] flg(input logic [1:0] cur, input logic [1:0] wr);
        if (wr == `CMOH_FLAG_SET || wr == `CMOH_FLAG_CLR) begin
            return wr;
        end
        return cur;
    endfunction : flg

    // Acceptance search, lowest match wins
    logic [N-1:0] acc;
    logic         hit;
    logic [4:0]   hobj;
    always_comb begin
        hit  = 1'b0;
        hobj = 5'h00;
        for (int i = 0; i < N; i++) begin
            acc[i] = ctrl_r[i][`CMOH_C_VAL] == `CMOH_FLAG_SET
                && setup_r[i][`CMOH_S_NODE] == rx_node_i
                && setup_r[i][`CMOH_S_XTD] == rx_xtd_i
                && setup_r[i][`CMOH_S_DIR] == rx_rtr_i
                && (((id_r[i][28:0] ^ rx_id_i) & mask_r[i][28:0]) == 29'h0);
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (acc[i]) begin
                hit  = 1'b1;
                hobj = 5'(i);
            end
        end
    end

    // Transmit candidate per node
    logic [N-1:0] cand [2];
    logic [1:0]   chit;
    logic [4:0]   cobj [2];
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            chit[n] = 1'b0;
            cobj[n] = 5'h00;
            for (int i = 0; i < N; i++) begin
                cand[n][i] = ctrl_r[i][`CMOH_C_VAL] == `CMOH_FLAG_SET
                    && ctrl_r[i][`CMOH_C_SEND_REQUEST_FIELD] == `CMOH_FLAG_SET
                    && ctrl_r[i][`CMOH_C_LOCK] == `CMOH_FLAG_CLR
                    && setup_r[i][`CMOH_S_NODE] == n[0];
            end
            for (int i = N - 1; i >= 0; i--) begin
                if (cand[n][i]) begin
                    chit[n] = 1'b1;
                    cobj[n] = 5'(i);
                end
            end
        end
    end

    logic [1:0] start;
    logic [1:0] done;
    assign start[0] = tst_r[0] == cmoh_pkg::CMOH_IDLE && chit[0] && bus_idle_i[0];
    assign start[1] = tst_r[1] == cmoh_pkg::CMOH_IDLE && chit[1] && bus_idle_i[1];
    assign done[0]  = tst_r[0] == cmoh_pkg::CMOH_BUSY && tx_done_i[0];
    assign done[1]  = tst_r[1] == cmoh_pkg::CMOH_BUSY && tx_done_i[1];

    // Per-node transmit sequencer and frame copy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tst_r[0]  <= cmoh_pkg::CMOH_IDLE;
            tst_r[1]  <= cmoh_pkg::CMOH_IDLE;
            tobj_r[0] <= 5'h00;
            tobj_r[1] <= 5'h00;
            tx_rtr_o  <= 2'h0;
            tx_xtd_o  <= 2'h0;
            tx_id_o   <= 58'h0;
            tx_dlc_o  <= 8'h00;
            tx_data_o <= 128'h0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                case (tst_r[n])
                    cmoh_pkg::CMOH_IDLE: begin
                        if (start[n]) begin
                            tst_r[n]  <= cmoh_pkg::CMOH_BUSY;
                            tobj_r[n] <= cobj[n];
                            tx_rtr_o[n] <= ~setup_r[cobj[n]][`CMOH_S_DIR];
                            tx_xtd_o[n] <= setup_r[cobj[n]][`CMOH_S_XTD];
                            tx_id_o[n*29 +: 29] <= id_r[cobj[n]][28:0];
                            tx_dlc_o[n*4 +: 4]  <= setup_r[cobj[n]][`CMOH_S_DLC];
                            tx_data_o[n*64 +: 64] <= {phi_r[cobj[n]], plo_r[cobj[n]]};
                        end
                    end
                    default: begin
                        if (tx_done_i[n] || tx_fail_i[n]) begin
                            tst_r[n] <= cmoh_pkg::CMOH_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    assign tx_req_o = {tst_r[1] == cmoh_pkg::CMOH_BUSY, tst_r[0] == cmoh_pkg::CMOH_BUSY};
    assign tx_obj_o = {tobj_r[1], tobj_r[0]};

    // Frame counters: low 16 bits count, enable bit above
    logic fca_inc;
    logic fcb_inc;
    logic rx_store;
    assign rx_store = rx_vld_i && hit;
    assign fca_inc = fca_r[`CMOH_FC_EN]
        && (done[0] || (rx_store && !rx_node_i && !rx_rtr_i));
    assign fcb_inc = fcb_r[`CMOH_FC_EN]
        && (done[1] || (rx_store && rx_node_i && !rx_rtr_i));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fca_r <= 32'h0;
            fcb_r <= 32'h0;
        end else begin
            if (wr_i && addr_i == `CMOH_A_FCA) begin
                fca_r <= wdata_i;
            end else if (fca_inc) begin
                fca_r[15:0] <= fca_r[15:0] + 16'h1;
            end
            if (wr_i && addr_i == `CMOH_A_FCB) begin
                fcb_r <= wdata_i;
            end else if (fcb_inc) begin
                fcb_r[15:0] <= fcb_r[15:0] + 16'h1;
            end
        end
    end

    // Object storage; hardware events applied after software writes
    for (genvar g = 0; g < N; g++) begin : g_obj
        logic       wsw;
        logic       rxh;
        logic       dn;
        logic [7:0] cap;
        assign wsw = wr_i && wobj == 5'(g) && addr_i < `CMOH_A_FCA;
        assign rxh = rx_store && hobj == 5'(g);
        assign dn  = (done[0] && tobj_r[0] == 5'(g)) || (done[1] && tobj_r[1] == 5'(g));
        assign cap = setup_r[g][`CMOH_S_NODE] ? fcb_r[7:0] : fca_r[7:0];

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ctrl_r[g]  <= 32'h0000_0555;
                setup_r[g] <= 32'h0;
                id_r[g]    <= 32'h0;
                mask_r[g]  <= 32'h0;
                plo_r[g]   <= 32'h0;
                phi_r[g]   <= 32'h0;
                fgc_r[g]   <= 32'h0;
            end else begin
                if (wsw && wsel == `CMOH_W_CTRL) begin
                    ctrl_r[g][`CMOH_C_VAL]  <= flg(ctrl_r[g][`CMOH_C_VAL], wdata_i[1:0]);
                    ctrl_r[g][`CMOH_C_SEND_REQUEST_FIELD] <= flg(ctrl_r[g][`CMOH_C_SEND_REQUEST_FIELD], wdata_i[3:2]);
                    ctrl_r[g][`CMOH_C_NEW]  <= flg(ctrl_r[g][`CMOH_C_NEW], wdata_i[5:4]);
                    ctrl_r[g][`CMOH_C_LOCK] <= flg(ctrl_r[g][`CMOH_C_LOCK], wdata_i[7:6]);
                    ctrl_r[g][`CMOH_C_RMT]  <= flg(ctrl_r[g][`CMOH_C_RMT], wdata_i[9:8]);
                    ctrl_r[g][`CMOH_C_SEND_IRQ_ENABLE] <= flg(ctrl_r[g][`CMOH_C_SEND_IRQ_ENABLE], wdata_i[11:10]);
                    ctrl_r[g][`CMOH_C_RECEIVE_IRQ_ENABLE] <= flg(ctrl_r[g][`CMOH_C_RECEIVE_IRQ_ENABLE], wdata_i[13:12]);
                    // Pending bits: write 0 clears, 1 leaves
                    ctrl_r[g][16:14] <= ctrl_r[g][16:14] & wdata_i[16:14];
                end
                if (wsw && wsel == `CMOH_W_SETUP) setup_r[g] <= wdata_i;
                if (wsw && wsel == `CMOH_W_ID)    id_r[g]    <= wdata_i;
                if (wsw && wsel == `CMOH_W_MASK)  mask_r[g]  <= wdata_i;
                if (wsw && wsel == `CMOH_W_PLO)   plo_r[g]   <= wdata_i;
                if (wsw && wsel == `CMOH_W_PHI)   phi_r[g]   <= wdata_i;
                if (wsw && wsel == `CMOH_W_FGC)   fgc_r[g]   <= wdata_i;
                // Start of transmit: payload handed over
                if ((start[0] && cobj[0] == 5'(g)) || (start[1] && cobj[1] == 5'(g))) begin
                    if (setup_r[g][`CMOH_S_DIR]) begin
                        ctrl_r[g][`CMOH_C_NEW] <= `CMOH_FLAG_CLR;
                    end
                end
                if (rxh && rx_rtr_i) begin
                    // Set wins over a same-cycle software clear
                    ctrl_r[g][`CMOH_C_SEND_REQUEST_FIELD] <= `CMOH_FLAG_SET;
                    ctrl_r[g][`CMOH_C_RMT]  <= `CMOH_FLAG_SET;
                    if (setup_r[g][`CMOH_S_RMM]) begin
                        id_r[g][28:0] <= rx_id_i;
                        setup_r[g][`CMOH_S_DLC] <= rx_dlc_i;
                    end
                end
                if (rxh && !rx_rtr_i) begin
                    plo_r[g] <= rx_data_i[31:0];
                    phi_r[g] <= rx_data_i[63:32];
                    setup_r[g][`CMOH_S_DLC] <= rx_dlc_i;
                    // Lock position doubles as overwrite flag on receive objects
                    if (ctrl_r[g][`CMOH_C_NEW] == `CMOH_FLAG_SET) begin
                        ctrl_r[g][`CMOH_C_LOCK] <= `CMOH_FLAG_SET;
                    end
                    ctrl_r[g][`CMOH_C_NEW]  <= `CMOH_FLAG_SET;
                    ctrl_r[g][`CMOH_C_SNAP] <= cap;
                    if (ctrl_r[g][`CMOH_C_RECEIVE_IRQ_ENABLE] == `CMOH_FLAG_SET) begin
                        ctrl_r[g][`CMOH_C_IPND] <= 1'b1;
                        ctrl_r[g][`CMOH_C_RXIP] <= 1'b1;
                    end
                end
                if (dn) begin
                    ctrl_r[g][`CMOH_C_SEND_REQUEST_FIELD] <= `CMOH_FLAG_CLR;
                    ctrl_r[g][`CMOH_C_RMT]  <= `CMOH_FLAG_CLR;
                    if (setup_r[g][`CMOH_S_DIR]) begin
                        ctrl_r[g][`CMOH_C_SNAP] <= cap;
                        // Valid dropped only in one-shot mode
                        if (fgc_r[g][`CMOH_G_SDT]) begin
                            ctrl_r[g][`CMOH_C_VAL] <= `CMOH_FLAG_CLR;
                        end
                    end
                    if (ctrl_r[g][`CMOH_C_SEND_IRQ_ENABLE] == `CMOH_FLAG_SET) begin
                        ctrl_r[g][`CMOH_C_IPND] <= 1'b1;
                        ctrl_r[g][`CMOH_C_TXIP] <= 1'b1;
                    end
                end
            end
        end
    end

    // Register read, one cycle latency
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0;
        end else if (rd_i) begin
            if (addr_i == `CMOH_A_FCA) begin
                rdata_r <= fca_r;
            end else if (addr_i == `CMOH_A_FCB) begin
                rdata_r <= fcb_r;
            end else if (addr_i >= `CMOH_A_FCA) begin
                rdata_r <= 32'h0;
            end else if (wsel == `CMOH_W_CTRL) begin
                rdata_r <= ctrl_r[wobj] & 32'hFF01_FFFF;
            end else if (wsel == `CMOH_W_SETUP) begin
                rdata_r <= setup_r[wobj];
            end else if (wsel == `CMOH_W_ID) begin
                rdata_r <= id_r[wobj];
            end else if (wsel == `CMOH_W_MASK) begin
                rdata_r <= mask_r[wobj];
            end else if (wsel == `CMOH_W_PLO) begin
                rdata_r <= plo_r[wobj];
            end else if (wsel == `CMOH_W_PHI) begin
                rdata_r <= phi_r[wobj];
            end else if (wsel == `CMOH_W_FGC) begin
                rdata_r <= fgc_r[wobj];
            end else begin
                rdata_r <= 32'h0;
            end
        end else begin
            rdata_r <= 32'h0;
        end
    end
    assign rdata_o = rdata_r;
endmodule : cmoh_handler

//--- dv/cmoh_handler_assertions.sv
`timescale 1ns/1ps
module cmoh_handler_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0]  bus_idle_i,
    input wire logic [1:0]  tx_req_o,
    input wire logic [9:0]  tx_obj_o,
    input wire logic [57:0] tx_id_o,
    input wire logic [127:0] tx_data_o,
    input wire logic [1:0]  tx_done_i,
    input wire logic [1:0]  tx_fail_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_hold_a;
        tx_req_o[0] && !tx_done_i[0] && !tx_fail_i[0] |=> tx_req_o[0];
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("node A request dropped early");
    property p_drop_a;
        tx_req_o[0] && (tx_done_i[0] || tx_fail_i[0]) |=> !tx_req_o[0];
    endproperty
    a_drop_a: assert property (p_drop_a) else $error("node A request kept after end");
    property p_drop_b;
        tx_req_o[1] && (tx_done_i[1] || tx_fail_i[1]) |=> !tx_req_o[1];
    endproperty
    a_drop_b: assert property (p_drop_b) else $error("node B request kept after end");
    property p_idle_a;
        $rose(tx_req_o[0]) |-> $past(bus_idle_i[0]);
    endproperty
    a_idle_a: assert property (p_idle_a) else $error("node A start on busy bus");
    property p_idle_b;
        $rose(tx_req_o[1]) |-> $past(bus_idle_i[1]);
    endproperty
    a_idle_b: assert property (p_idle_b) else $error("node B start on busy bus");
    property p_stab_a;
        tx_req_o[0] ##1 tx_req_o[0] |-> $stable(tx_obj_o[4:0]) && $stable(tx_data_o[63:0]);
    endproperty
    a_stab_a: assert property (p_stab_a) else $error("node A frame changed in flight");
    property p_stab_b;
        tx_req_o[1] ##1 tx_req_o[1] |-> $stable(tx_id_o[57:29]) && $stable(tx_obj_o[9:5]);
    endproperty
    a_stab_b: assert property (p_stab_b) else $error("node B frame changed in flight");
    c_tx_a: cover property ($rose(tx_req_o[0]));
    c_tx_b: cover property ($rose(tx_req_o[1]));
    c_fail: cover property (tx_req_o[1] && tx_fail_i[1]);
endmodule : cmoh_handler_chk
bind cmoh_handler cmoh_handler_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .bus_idle_i(bus_idle_i), .tx_req_o(tx_req_o), .tx_obj_o(tx_obj_o),
    .tx_id_o(tx_id_o), .tx_data_o(tx_data_o), .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i));

//--- dv/cmoh_partner.sv
`timescale 1ns/1ps
module cmoh_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] tx_req_i,
    input  wire logic [1:0] hold_i,
    input  wire logic       slow_i,
    input  wire logic [1:0] fail_i,
    output logic      [1:0] bus_idle_o,
    output logic      [1:0] tx_done_o,
    output logic      [1:0] tx_fail_o
);
    logic [4:0] cnt_r [2];
    logic [1:0] used_r;
    // Own frame keeps the bus busy too
    assign bus_idle_o = ~hold_i & ~tx_req_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        for (int n = 0; n < 2; n++) begin
            if (rst_i) begin
                cnt_r[n] <= 5'h0;
                used_r[n] <= 1'b0;
                tx_done_o[n] <= 1'b0;
                tx_fail_o[n] <= 1'b0;
            end else begin
                tx_done_o[n] <= 1'b0;
                tx_fail_o[n] <= 1'b0;
                if (!fail_i[n]) used_r[n] <= 1'b0;
                if (!tx_req_i[n] || tx_done_o[n] || tx_fail_o[n]) begin
                    cnt_r[n] <= 5'h0;
                end else if (cnt_r[n] == (slow_i ? 5'h14 : 5'h03)) begin
                    cnt_r[n] <= 5'h0;
                    // One abort per command, then success
                    if (fail_i[n] && !used_r[n]) begin
                        tx_fail_o[n] <= 1'b1;
                        used_r[n] <= 1'b1;
                    end else begin
                        tx_done_o[n] <= 1'b1;
                    end
                end else begin
                    cnt_r[n] <= cnt_r[n] + 5'h1;
                end
            end
        end
    end
endmodule : cmoh_partner

//--- dv/cmoh_handler_tb_top.sv
`timescale 1ns/1ps
`include "cmoh_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module cmoh_handler_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0;
    logic rx_vld_i = 1'b0, rx_node_i = 1'b0, rx_rtr_i = 1'b0;
    logic [7:0]   addr_i = 8'h00, tx_dlc_o;
    logic [31:0]  wdata_i = 32'h0, rdata_o, d, d2;
    logic [28:0]  rx_id_i = 29'h0;
    logic [3:0]   rx_dlc_i = 4'h0, dl;
    logic [63:0]  rx_data_i = 64'h0, dt;
    logic [1:0]   bus_idle_i, tx_req_o, tx_rtr_o, tx_xtd_o, tx_done_i, tx_fail_i;
    logic [1:0]   hold = 2'h3, fail = 2'h0;
    logic [9:0]   tx_obj_o;
    logic [57:0]  tx_id_o;
    logic [127:0] tx_data_o;
    logic [16:0]  m [32];
    logic [7:0]   ms [32];
    logic [28:0]  eid [32];
    logic [3:0]   edlc [32];
    logic [63:0]  epl [32];
    logic         os [32];
    logic [15:0]  fc [2];
    int           n_fail = 0, comparisons = 0, k, j, seed = 32'h2bd8a400;
    localparam logic [13:0] F_TX0 = {2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1, 2'h2};
    localparam logic [13:0] F_TX1 = {2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
    localparam logic [13:0] F_RX0 = {2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
    always #5 clk_i = ~clk_i;
    cmoh_handler u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_vld_i(rx_vld_i), .rx_node_i(rx_node_i),
        .rx_rtr_i(rx_rtr_i), .rx_xtd_i(1'b0), .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i),
        .rx_data_i(rx_data_i), .bus_idle_i(bus_idle_i), .tx_req_o(tx_req_o), .tx_obj_o(tx_obj_o),
        .tx_rtr_o(tx_rtr_o), .tx_xtd_o(tx_xtd_o), .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o),
        .tx_data_o(tx_data_o), .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i));
    cmoh_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .tx_req_i(tx_req_o), .hold_i(hold),
        .slow_i(slow), .fail_i(fail), .bus_idle_o(bus_idle_i), .tx_done_o(tx_done_i),
        .tx_fail_o(tx_fail_i));
    function automatic logic [16:0] fl(input logic [16:0] v, input logic [13:0] f);
        for (int i = 0; i < 7; i++)
            if (f[2*i+:2] == `CMOH_FLAG_SET || f[2*i+:2] == `CMOH_FLAG_CLR) v[2*i+:2] = f[2*i+:2];
        return v;
    endfunction : fl
    function automatic logic [63:0] bm(input logic [3:0] n);
        return (n >= 4'h8) ? {64{1'b1}} : (64'h1 << (8 * n)) - 64'h1;
    endfunction : bm
    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_i); addr_i <= a; wdata_i <= w; wr_i <= 1'b1;
        @(posedge clk_i); wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i); rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // Irq pending bits written as 1 so software never clears them by accident
    task automatic wc(input logic [4:0] o, input logic [13:0] f);
        wr({o, `CMOH_W_CTRL}, {15'h0, 3'h7, f});
        m[o] = fl(m[o], f);
    endtask : wc
    task automatic cc(input logic [4:0] o, input logic s);
        rd({o, `CMOH_W_CTRL});
        `CHK(d[16:0], m[o])
        if (s) `CHK(d[31:24], ms[o])
    endtask : cc
    task automatic setobj(input logic [4:0] o, input logic [13:0] f0, input logic [3:0] s,
                          input logic [28:0] id, input logic [13:0] f1);
        wc(o, f0);
        edlc[o] = 4'($random(seed) & 7); epl[o] = {$random(seed), $random(seed)}; eid[o] = id;
        wr({o, `CMOH_W_SETUP}, {24'h0, edlc[o], s}); wr({o, `CMOH_W_ID}, {3'h0, id});
        wr({o, `CMOH_W_MASK}, 32'h1FFFFFFF); wr({o, `CMOH_W_PLO}, epl[o][31:0]);
        wr({o, `CMOH_W_PHI}, epl[o][63:32]); wr({o, `CMOH_W_FGC}, {31'h0, os[o]});
        wc(o, f1);
    endtask : setobj
    task automatic wl(input int n, input logic v);
        for (k = 0; k < 400 && tx_req_o[n] !== v; k++) begin @(posedge clk_i); #1; end
        if (k == 400) begin n_fail++; wrap_up(); end
    endtask : wl
    task automatic txw(input int n, input logic [4:0] o, input logic r);
        wl(n, 1'b1);
        `CHK(tx_obj_o[5*n+:5], o)
        `CHK(tx_rtr_o[n], r)
        `CHK(tx_xtd_o[n], 1'b0)
        `CHK(tx_id_o[29*n+:29], eid[o])
        if (!r) `CHK(tx_dlc_o[4*n+:4], edlc[o])
        if (!r) `CHK(tx_data_o[64*n+:64] & bm(edlc[o]), epl[o] & bm(edlc[o]))
        wl(n, 1'b0);
        m[o][3:2] = 2'h1; m[o][9:8] = 2'h1;
        if (!r) m[o][5:4] = 2'h1;
        if (m[o][11:10] == 2'h2) m[o][15:14] = 2'h3;
        if (os[o]) m[o][1:0] = 2'h1;
        ms[o] = fc[n][7:0]; fc[n]++;
        cc(o, !r);
    endtask : txw
    task automatic rxf(input logic r, input logic [28:0] id, input logic [3:0] l, input logic [63:0] x);
        @(posedge clk_i); rx_vld_i <= 1'b1; rx_rtr_i <= r; rx_id_i <= id; rx_dlc_i <= l; rx_data_i <= x;
        @(posedge clk_i); rx_vld_i <= 1'b0; rx_id_i <= ~id; rx_data_i <= ~x;
    endtask : rxf
    initial begin
        for (k = 0; k < 32; k++) begin m[k] = 17'h0555; ms[k] = 8'h0; os[k] = 1'b0; end
        fc[0] = 16'($random(seed)); fc[1] = 16'h0; os[5] = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        cc(5'($random(seed)), 1'b1);
        wr(8'h0F, 32'hFFFFFFFF); rd(8'h0F); `CHK(d, 32'h0)
        rd(8'hFA); `CHK(d, 32'h0)
        wr(`CMOH_A_FCA, {15'h0, 1'b1, fc[0]});
        for (j = 0; j < 4; j++) begin wc(5'h3, {7{2'(j + 2)}}); cc(5'h3, 1'b0); end
        setobj(5'h5, F_TX0, 4'h1, 29'h345, F_TX1);
        setobj(5'h2, F_TX0, 4'h9, 29'h120, F_TX1);
        hold <= 2'h0;
        txw(0, 5'h2, 1'b0);
        txw(0, 5'h5, 1'b0);
        wc(5'h2, {6'h0, 2'h2, 6'h0});
        rxf(1'b1, eid[2], 4'h3, 64'h0);
        m[2][3:2] = 2'h2; m[2][9:8] = 2'h2; edlc[2] = 4'h3;
        cc(5'h2, 1'b0);
        rd({5'h2, `CMOH_W_SETUP}); `CHK(d[7:4], 4'h3)
        repeat (10) @(posedge clk_i);
        #1 `CHK(tx_req_o[0], 1'b0)
        wc(5'h2, {6'h0, 2'h1, 6'h0});
        txw(0, 5'h2, 1'b0);
        rxf(1'b1, eid[5], 4'h2, 64'h0); cc(5'h5, 1'b0);
        setobj(5'h7, F_RX0, 4'h0, 29'h0AA, 14'h0);
        setobj(5'h9, F_RX0, 4'h0, 29'h0AA, 14'h0);
        rxf(1'b0, eid[2], 4'h8, 64'h0); cc(5'h2, 1'b0);
        for (j = 0; j < 2; j++) begin
            dt = {$random(seed), $random(seed)}; dl = 4'($random(seed) & 7) + 4'h1;
            rxf(1'b0, 29'h0AA, dl, dt);
            if (m[7][5:4] == 2'h2) m[7][7:6] = 2'h2;
            m[7][5:4] = 2'h2; m[7][16] = 1'b1; m[7][14] = 1'b1; ms[7] = fc[0][7:0]; fc[0]++;
            cc(5'h7, 1'b1);
            cc(5'h9, 1'b0);
            rd({5'h7, `CMOH_W_PLO}); d2 = d; rd({5'h7, `CMOH_W_PHI});
            `CHK({d, d2} & bm(dl), dt & bm(dl))
            rd({5'h7, `CMOH_W_SETUP}); `CHK(d[7:4], dl)
        end
        rxf(1'b1, 29'h0AA, 4'h1, 64'h0); cc(5'h7, 1'b0);
        setobj(5'hC, F_RX0, 4'h2, 29'h055, 14'h0);
        slow <= 1'b1; fail <= 2'h2;
        wc(5'hC, {6'h0, 2'h2, 2'h0, 2'h2, 2'h0});
        repeat (10) @(posedge clk_i);
        #1 `CHK(tx_req_o[1], 1'b0)
        wc(5'hC, {6'h0, 2'h1, 6'h0});
        wl(1, 1'b1); wl(1, 1'b0);
        fail <= 2'h0;
        txw(1, 5'hC, 1'b1);
        wrap_up();
    end
endmodule : cmoh_handler_tb_top
